// >>> rtl/card_bus_init_spi_framing.sv
`timescale 1ns/10ps
module card_bus_init_spi_framing #(
	parameter int unsigned INIT_CYCLES = card_bus_pkg::INIT_CYCLES,
	parameter logic [23:0] OCR_PROFILE = card_bus_pkg::OCR_PROFILE_RST
) (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic link_clk,
	input  wire logic host_to_card_line,
	input  wire logic reserved_pad_n,
	output logic      cmd_out,
	output logic      cmd_oe,
	output logic      card_to_host_line,
	output logic      card_to_host_oe,
	output logic      card_ready
);

	localparam int CW = $clog2(INIT_CYCLES + 1);

	// Synchroniser stages, third clock stage for edge finding
	logic clk_s1_reg, clk_s2_reg, clk_s3_reg;
	logic din_s1_reg, din_s2_reg;
	logic sel_s1_reg, sel_s2_reg;

	logic link_rise, link_fall, sel_now, din;

	// Control state
	card_bus_pkg::card_state_t state_reg, state_next;
	logic [6:0]    ones_cnt_reg, ones_cnt_next;
	logic          spi_mode_reg, spi_mode_next;
	logic          init_run_reg, init_run_next;
	logic          init_done_reg, init_done_next;
	logic [CW-1:0] init_cnt_reg, init_cnt_next;
	logic          tx_load, busy_resp, illegal;
	logic [7:0]    r1;
	logic [47:0]   tx_word;
	logic [5:0]    tx_len;

	// Receive state
	logic        rx_active_reg, rx_active_next;
	logic [5:0]  rx_cnt_reg, rx_cnt_next;
	logic [47:0] rx_sh_reg, rx_sh_next;
	logic [2:0]  align_reg, align_next;
	logic        cmd_stb_reg, cmd_stb_next;
	logic [5:0]  cmd_idx;

	// Transmit state
	logic        tx_active_reg, tx_active_next;
	logic        tx_spi_reg, tx_spi_next;
	logic [5:0]  tx_cnt_reg, tx_cnt_next;
	logic [47:0] tx_sh_reg, tx_sh_next;
	logic        cmd_out_reg, cmd_out_next;
	logic        cmd_oe_reg, cmd_oe_next;
	logic        dout_reg, dout_next;
	logic        dout_oe_reg, dout_oe_next;

	// Bring pins into the core domain
	always_ff @(posedge core_clk) begin
		if (rst) begin
			clk_s1_reg <= 1'b0;
			clk_s2_reg <= 1'b0;
			clk_s3_reg <= 1'b0;
			din_s1_reg <= 1'b1;
			din_s2_reg <= 1'b1;
			sel_s1_reg <= 1'b1;
			sel_s2_reg <= 1'b1;
		end else begin
			clk_s1_reg <= link_clk;
			clk_s2_reg <= clk_s1_reg;
			clk_s3_reg <= clk_s2_reg;
			din_s1_reg <= host_to_card_line;
			din_s2_reg <= din_s1_reg;
			sel_s1_reg <= reserved_pad_n;
			sel_s2_reg <= sel_s1_reg;
		end
	end

	// Sample on rising link edges, shift out on falling ones
	assign link_rise = clk_s2_reg & ~clk_s3_reg;
	assign link_fall = ~clk_s2_reg & clk_s3_reg;
	assign sel_now   = ~sel_s2_reg;     // Pad held high in native mode
	assign din       = din_s2_reg;      // Commands always on this pad
	assign cmd_idx   = rx_sh_reg[45:40];

	// Power-up, idle handling and command decode
	always_comb begin
		state_next     = state_reg;
		ones_cnt_next  = ones_cnt_reg;
		spi_mode_next  = spi_mode_reg;
		init_run_next  = init_run_reg;
		init_done_next = init_done_reg;
		init_cnt_next  = init_cnt_reg;
		tx_load        = 1'b0;
		illegal        = 1'b0;
		busy_resp      = ~init_done_reg;
		// Internal power-up runs whatever chip select does
		if (init_run_reg && !init_done_reg) begin
			if (init_cnt_reg == CW'(INIT_CYCLES - 1)) begin
				init_done_next = 1'b1;
			end else begin
				init_cnt_next = init_cnt_reg + 1'b1;
			end
		end
		case (state_reg)
			// After reset wait for a running clock with ones
			card_bus_pkg::st_wait_ones: begin
				if (link_rise) begin
					if (!din) begin
						ones_cnt_next = 7'h00;
					end else if (ones_cnt_reg ==
						7'(card_bus_pkg::INIT_ONES_READY - 1)) begin
						state_next = card_bus_pkg::st_idle;
					end else begin
						ones_cnt_next = ones_cnt_reg + 1'b1;
					end
				end
			end
			// Only the operating-condition command leaves idle
			card_bus_pkg::st_idle: begin
				if (cmd_stb_reg && cmd_idx == card_bus_pkg::CMD_SEND_OP) begin
					state_next    = card_bus_pkg::st_ready;
					init_run_next = 1'b1;
					spi_mode_next = sel_now;
					tx_load       = 1'b1;
				end
			end
			card_bus_pkg::st_ready: begin
				if (cmd_stb_reg) begin
					if (cmd_idx == card_bus_pkg::CMD_SEND_OP) begin
						tx_load = 1'b1;
					end else if (cmd_idx == card_bus_pkg::CMD_GO_IDLE) begin
						state_next     = card_bus_pkg::st_idle;
						init_run_next  = 1'b0;
						init_done_next = 1'b0;
						init_cnt_next  = '0;
						spi_mode_next  = sel_now;
						busy_resp      = 1'b1;
						tx_load        = sel_now;
					end else begin
						// Reduced command set: others flagged in SPI
						illegal = 1'b1;
						tx_load = spi_mode_reg;
					end
				end
			end
			default: begin
				state_next = card_bus_pkg::st_wait_ones;
			end
		endcase
		r1 = 8'h00;
		r1[card_bus_pkg::R1_IDLE_POS]    = busy_resp;
		r1[card_bus_pkg::R1_ILLEGAL_POS] = illegal;
		if (sel_now) begin
			tx_word = {r1, 40'h00_0000_0000};
			tx_len  = 6'(card_bus_pkg::SPI_RESP_BITS);
		end else begin
			tx_word = {2'b00, 6'h3F, busy_resp, 7'h00, OCR_PROFILE, 7'h7F, 1'b1};
			tx_len  = 6'(card_bus_pkg::NATIVE_RESP_BITS);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg     <= card_bus_pkg::st_wait_ones;
			ones_cnt_reg  <= 7'h00;
			spi_mode_reg  <= 1'b0;
			init_run_reg  <= 1'b0;
			init_done_reg <= 1'b0;
			init_cnt_reg  <= '0;
		end else begin
			state_reg     <= state_next;
			ones_cnt_reg  <= ones_cnt_next;
			spi_mode_reg  <= spi_mode_next;
			init_run_reg  <= init_run_next;
			init_done_reg <= init_done_next;
			init_cnt_reg  <= init_cnt_next;
		end
	end

	// Command frame receiver
	always_comb begin
		rx_active_next = rx_active_reg;
		rx_cnt_next    = rx_cnt_reg;
		rx_sh_next     = rx_sh_reg;
		align_next     = align_reg;
		cmd_stb_next   = 1'b0;
		// Byte phase restarts at each select
		if (!sel_now) begin
			align_next = 3'h0;
		end else if (link_rise) begin
			align_next = align_reg + 1'b1;
		end
		if (spi_mode_reg && !sel_now) begin
			rx_active_next = 1'b0;
		end else if (link_rise && !tx_active_reg &&
			state_reg != card_bus_pkg::st_wait_ones) begin
			// Nothing is taken while an answer goes out
			if (!rx_active_reg) begin
				if (!din && (!sel_now || align_reg == 3'h0)) begin
					rx_active_next = 1'b1;
					rx_cnt_next    = 6'h01;
					rx_sh_next     = {rx_sh_reg[46:0], din};
				end
			end else begin
				rx_sh_next = {rx_sh_reg[46:0], din};
				if (rx_cnt_reg == 6'(card_bus_pkg::CMD_FRAME_BITS - 1)) begin
					rx_active_next = 1'b0;
					rx_cnt_next    = 6'h00;
					cmd_stb_next   = 1'b1;
				end else begin
					rx_cnt_next = rx_cnt_reg + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rx_active_reg <= 1'b0;
			rx_cnt_reg    <= 6'h00;
			rx_sh_reg     <= 48'h0000_0000_0000;
			align_reg     <= 3'h0;
			cmd_stb_reg   <= 1'b0;
		end else begin
			rx_active_reg <= rx_active_next;
			rx_cnt_reg    <= rx_cnt_next;
			rx_sh_reg     <= rx_sh_next;
			align_reg     <= align_next;
			cmd_stb_reg   <= cmd_stb_next;
		end
	end

	// Response transmitter and pad drivers
	always_comb begin
		tx_active_next = tx_active_reg;
		tx_spi_next    = tx_spi_reg;
		tx_cnt_next    = tx_cnt_reg;
		tx_sh_next     = tx_sh_reg;
		cmd_out_next   = 1'b0;              // Open drain only pulls low
		cmd_oe_next    = cmd_oe_reg;
		dout_next      = dout_reg;
		dout_oe_next   = sel_now && (spi_mode_reg || tx_active_reg || tx_load);
		if (tx_load) begin
			tx_active_next = 1'b1;
			tx_spi_next    = sel_now;
			tx_cnt_next    = tx_len;
			tx_sh_next     = tx_word;
		end else if (link_fall && tx_active_reg) begin
			if (tx_cnt_reg != 6'h00) begin
				tx_sh_next  = {tx_sh_reg[46:0], 1'b1};
				tx_cnt_next = tx_cnt_reg - 1'b1;
				if (tx_spi_reg) begin
					dout_next = tx_sh_reg[47];
				end else begin
					cmd_oe_next = ~tx_sh_reg[47];
				end
			end else begin
				tx_active_next = 1'b0;
				cmd_oe_next    = 1'b0;
				dout_next      = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_active_reg <= 1'b0;
			tx_spi_reg    <= 1'b0;
			tx_cnt_reg    <= 6'h00;
			tx_sh_reg     <= 48'hFFFF_FFFF_FFFF;
			cmd_out_reg   <= 1'b0;
			cmd_oe_reg    <= 1'b0;
			dout_reg      <= 1'b1;
			dout_oe_reg   <= 1'b0;
		end else begin
			tx_active_reg <= tx_active_next;
			tx_spi_reg    <= tx_spi_next;
			tx_cnt_reg    <= tx_cnt_next;
			tx_sh_reg     <= tx_sh_next;
			cmd_out_reg   <= cmd_out_next;
			cmd_oe_reg    <= cmd_oe_next;
			dout_reg      <= dout_next;
			dout_oe_reg   <= dout_oe_next;
		end
	end

	assign cmd_out           = cmd_out_reg;
	assign cmd_oe            = cmd_oe_reg;
	assign card_to_host_line = dout_reg;
	assign card_to_host_oe   = dout_oe_reg;
	assign card_ready        = init_done_reg;

	// Checks next to the logic they guard
	a_ones_ready: assert property (@(posedge core_clk) disable iff (rst)
		(state_reg == card_bus_pkg::st_wait_ones &&
		 state_next == card_bus_pkg::st_idle) |-> ones_cnt_reg == 7'h3F)
		else $error("Left reset wait before 64 ones");
	a_idle_ignore: assert property (@(posedge core_clk) disable iff (rst)
		(state_reg == card_bus_pkg::st_idle && cmd_stb_reg &&
		 cmd_idx != card_bus_pkg::CMD_SEND_OP) |=> !tx_active_reg)
		else $error("Idle card answered a command");
	a_busy_flag: assert property (@(posedge core_clk) disable iff (rst)
		(tx_load && !sel_now && cmd_idx == card_bus_pkg::CMD_SEND_OP)
		|=> tx_sh_reg[8 + card_bus_pkg::OCR_BUSY_POS] == $past(!init_done_reg))
		else $error("Busy flag does not match power-up state");
	a_init_done: assert property (@(posedge core_clk) disable iff (rst)
		(init_run_reg && !init_done_reg &&
		 init_cnt_reg == CW'(INIT_CYCLES - 1)) |=> init_done_reg)
		else $error("Power-up did not finish on time");
	a_prog_cont: assert property (@(posedge core_clk) disable iff (rst)
		(init_run_reg && !init_done_reg && !sel_now &&
		 init_cnt_reg != CW'(INIT_CYCLES - 1))
		|=> init_cnt_reg == $past(init_cnt_reg) + 1'b1)
		else $error("Power-up stalled while deselected");
	a_no_rx_tx: assert property (@(posedge core_clk) disable iff (rst)
		tx_active_reg |-> !rx_active_reg && !cmd_stb_reg)
		else $error("Command taken during a transfer");
	a_byte_align: assert property (@(posedge core_clk) disable iff (rst)
		(!rx_active_reg && rx_active_next && sel_now) |-> align_reg == 3'h0)
		else $error("SPI frame not byte aligned");
	a_dout_desel: assert property (@(posedge core_clk) disable iff (rst)
		!sel_now |=> !card_to_host_oe)
		else $error("Output driven while deselected");
	a_od_drive: assert property (@(posedge core_clk) disable iff (rst)
		cmd_oe |-> !cmd_out && !tx_spi_reg)
		else $error("Command line driven high in open drain");

endmodule

// >>> rtl/card_bus_pkg.sv
package card_bus_pkg;

	// Core clock and power-up limit
	localparam int unsigned CORE_CLK_HZ      = 200_000_000;
	localparam int unsigned INIT_TIME_MS     = 500;
	localparam int unsigned INIT_CYCLES      = INIT_TIME_MS * (CORE_CLK_HZ / 1000);

	// Link framing
	localparam int unsigned INIT_ONES_READY  = 64;
	localparam int unsigned CMD_FRAME_BITS   = 48;
	localparam int unsigned SPI_RESP_BITS    = 8;
	localparam int unsigned NATIVE_RESP_BITS = 48;

	// Command indices
	localparam logic [5:0]  CMD_GO_IDLE      = 6'h00;
	localparam logic [5:0]  CMD_SEND_OP      = 6'h01;

	// Operating condition word and flag positions
	localparam logic [23:0] OCR_PROFILE_RST  = 24'hFF8000;
	localparam int unsigned OCR_BUSY_POS     = 31;
	localparam int unsigned R1_IDLE_POS      = 0;
	localparam int unsigned R1_ILLEGAL_POS   = 2;

	typedef enum logic [1:0] {
		st_wait_ones,
		st_idle,
		st_ready
	} card_state_t;

endpackage

// >>> testbench/host_model.sv
`timescale 1ns/10ps
module host_model (
	output logic      link_clk,
	output logic      host_to_card_line,
	output logic      reserved_pad_n,
	input  wire logic cmd_out,
	input  wire logic cmd_oe,
	input  wire logic card_to_host_line
);
	logic host_oe;
	logic host_val;

	// Wired command line: pull-up unless the host or the card pulls low
	assign host_to_card_line = ((host_oe && !host_val) || (cmd_oe && !cmd_out))
		? 1'h0 : 1'h1;

	// Clock idles low, line idles high, card not selected
	initial begin
		link_clk = 1'h0;
		host_oe = 1'h1;
		host_val = 1'h1;
		reserved_pad_n = 1'h1;
	end

	// One link clock: bit set while low, answer sampled at the rising edge
	task automatic clk_bit(input logic b, output logic s);
		host_val = b;
		#62.5;
		link_clk = 1'h1;
		s = reserved_pad_n ? host_to_card_line : card_to_host_line;
		#62.5;
		link_clk = 1'h0;
	endtask

	// Contiguous run of ones, clock stops afterwards
	task automatic send_ones(input int n);
		logic s;
		repeat (n) clk_bit(1'h1, s);
	endtask

	// Select is changed only with the clock stopped
	task automatic select(input logic on);
		reserved_pad_n = !on;
	endtask

	// Six-byte command frame, then nresp clocks to collect the answer
	task automatic send_cmd(input logic [5:0] idx, input int nresp,
		output logic [47:0] resp);
		logic [47:0] f;
		logic        s;
		f = {2'h1, idx, 32'h0000_0000, 8'hFF};
		for (int i = 47; i >= 0; i--) clk_bit(f[i], s);
		host_oe = !reserved_pad_n; // Release the wire in native mode
		resp = 48'hFFFF_FFFF_FFFF;
		for (int i = 0; i < nresp; i++) begin
			clk_bit(1'h1, s);
			resp = {resp[46:0], s};
		end
		host_oe = 1'h1;
	endtask
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	localparam int unsigned INIT_N = 4000;
	// Busy is seen at strobes spaced 96 link clocks (2400 core cycles) apart
	localparam int          POLLS  = (INIT_N + 2399) / 2400 + 1;
	localparam logic [47:0] QUIET  = 48'hFFFF_FFFF_FFFF;
	logic        core_clk;
	logic        rst;
	logic        link_clk;
	logic        h2c;
	logic        sel_n;
	logic        cmd_out;
	logic        cmd_oe;
	logic        c2h;
	logic        c2h_oe;
	logic        card_ready;
	logic        s;
	logic [47:0] resp;
	int          n_fail;
	int          n_checks;
	int          polls;

	card_bus_init_spi_framing #(.INIT_CYCLES(INIT_N))
		card_bus_init_spi_framing_inst (
		.core_clk(core_clk), .rst(rst), .link_clk(link_clk),
		.host_to_card_line(h2c), .reserved_pad_n(sel_n),
		.cmd_out(cmd_out), .cmd_oe(cmd_oe), .card_to_host_line(c2h),
		.card_to_host_oe(c2h_oe), .card_ready(card_ready));

	host_model host_model_inst (
		.link_clk(link_clk), .host_to_card_line(h2c),
		.reserved_pad_n(sel_n), .cmd_out(cmd_out), .cmd_oe(cmd_oe),
		.card_to_host_line(c2h));

	// Core clock
	initial begin
		core_clk = 1'h0;
		forever #2.5 core_clk = ~core_clk;
	end

	// Compare and count
	task automatic check(input string what, input logic [47:0] exp,
		input logic [47:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Expected native answer to the operating-condition command
	function automatic logic [47:0] op_ans(input logic busy);
		return {8'h3F, busy, 7'h00, card_bus_pkg::OCR_PROFILE_RST, 8'hFF};
	endfunction

	task automatic do_reset();
		@(negedge core_clk);
		rst = 1'h1;
		repeat (3) @(negedge core_clk);
		rst = 1'h0;
		@(negedge core_clk);
		check("idle outputs", 48'h4, 48'({cmd_oe, c2h, c2h_oe, card_ready}));
	endtask

	// Too few ones: the card stays deaf
	task automatic t_early();
		host_model_inst.clk_bit(1'h0, s);
		host_model_inst.send_ones(63);
		host_model_inst.send_cmd(6'h01, 48, resp);
		check("early answer", QUIET, resp);
	endtask

	// 64 ones, then poll until the busy flag clears
	task automatic t_power_up();
		host_model_inst.clk_bit(1'h0, s);
		host_model_inst.send_ones(64);
		polls = 0;
		do begin
			host_model_inst.send_cmd(6'h01, 48, resp);
			polls++;
			check("ready flag", 48'(polls > POLLS - 1), 48'(card_ready));
		end while (resp === op_ans(1'h1) && polls < 10);
		check("poll count", 48'(POLLS), 48'(polls));
		check("ready answer", op_ans(1'h0), resp);
	endtask

	// Ready card: other commands silent, reset restarts power-up
	task automatic t_native_cmds();
		host_model_inst.send_cmd(6'h02, 48, resp);
		check("other cmd", QUIET, resp);
		host_model_inst.send_cmd(6'h00, 48, resp);
		check("go idle", QUIET, resp);
		host_model_inst.send_cmd(6'h01, 48, resp);
		check("restart", op_ans(1'h1), resp);
		check("not ready", 48'h0, 48'(card_ready));
	endtask

	// Select-framed bytes; busy keeps counting while deselected
	task automatic t_spi();
		do_reset();
		host_model_inst.send_ones(74);
		host_model_inst.select(1'h1);
		#20;
		check("out enable", 48'h0, 48'(c2h_oe));
		host_model_inst.send_cmd(6'h01, 8, resp);
		check("spi busy", {40'hFF_FFFF_FFFF, 8'h01}, resp);
		host_model_inst.send_cmd(6'h05, 8, resp);
		check("spi illegal", {40'hFF_FFFF_FFFF, 8'h05}, resp);
		check("cmd wire", 48'h0, 48'(cmd_oe));
		host_model_inst.select(1'h0);
		repeat (INIT_N + 50) @(negedge core_clk);
		check("deselected", 48'h1, 48'({c2h_oe, card_ready}));
		host_model_inst.select(1'h1);
		host_model_inst.send_cmd(6'h01, 8, resp);
		check("spi ready", {40'hFF_FFFF_FFFF, 8'h00}, resp);
		host_model_inst.send_cmd(6'h00, 8, resp);
		check("spi idle", {40'hFF_FFFF_FFFF, 8'h01}, resp);
		host_model_inst.select(1'h0);
	endtask

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		n_fail = 0;
		n_checks = 0;
		rst = 1'h1;
		do_reset();
		t_early();
		t_power_up();
		t_native_cmds();
		t_spi();
		wrap_up();
	end

	// Watchdog well beyond the expected run of about 160 us
	initial begin
		#400000;
		n_fail++;
		wrap_up();
	end
endmodule
